// file: include/lcs_pkg.sv
// package: register map, field positions and reset values of the line control/status block
package lcs_pkg;
	// register addresses on the parallel control port
	localparam logic [7:0] ADDR_LINE_IF_CTRL = 8'h0A;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h20;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h21;
	localparam logic [7:0] ADDR_RX_INFO_ONE = 8'h22;
	localparam logic [7:0] ADDR_RX_INFO_TWO = 8'h31;
	localparam logic [7:0] ADDR_RX_INFO_THREE = 8'h10;
	localparam logic [7:0] ADDR_HDLC_STATUS = 8'h12;
	localparam logic [7:0] ADDR_IRQ_MASK_ONE = 8'h7C;
	localparam logic [7:0] ADDR_IRQ_MASK_TWO = 8'h7D;
	localparam logic [7:0] ADDR_HDLC_IRQ_MASK = 8'h7E;
	// status register indices
	localparam int IDX_STATUS_ONE = 0;
	localparam int IDX_STATUS_TWO = 1;
	localparam int IDX_RX_INFO_ONE = 2;
	localparam int IDX_RX_INFO_TWO = 3;
	localparam int IDX_RX_INFO_THREE = 4;
	localparam int IDX_HDLC_STATUS = 5;
	localparam int NUM_STATUS = 6;
	// line interface control field positions
	localparam int BIT_LINE_IF_RESET = 7;
	localparam int BIT_REMOTE_LOOPBACK = 6;
	localparam int BIT_RX_ELASTIC_RESET = 5;
	localparam int BIT_TX_ELASTIC_RESET = 4;
	localparam int BIT_RESERVED = 3;
	localparam int BIT_SYNC_INPUT_SELECT = 2;
	localparam int BIT_TEST_PATTERN = 1;
	localparam int BIT_DRIVER_OPEN_DRAIN = 0;
	// alarm positions in status register one: sync loss, carrier loss, blue, yellow
	localparam logic [7:0] STATUS_ONE_ALARM_MASK = 8'h0F;
	localparam int NUM_ALARMS = 4;
	// reset values
	localparam logic [7:0] LINE_IF_CTRL_RST = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : lcs_pkg

// file: hw/lcs_top.sv
// module: line interface control register, latched status registers and interrupt output
`timescale 1ns/10ps
module lcs_top (
	input wire logic core_clk_in, // 20 MHz core clock
	input wire logic arst_n_in, // asynchronous reset, active low
	input wire logic [7:0] addr_in, // control port address
	input wire logic [7:0] wdata_in, // control port write data
	input wire logic wr_in, // write strobe, one cycle
	input wire logic rd_in, // read strobe, one cycle
	output logic [7:0] rdata_out, // read data, valid cycle after rd_in
	output logic int_n_out, // interrupt, active low
	input wire logic [47:0] status_set_in, // event pulses, byte per status register
	input wire logic [3:0] alarm_in, // alarm levels: sync, carrier, blue, yellow
	input wire logic tx_bit_en_in, // one pulse per transmit bit period
	input wire logic rx_line_pos_in, // receive positive rail
	input wire logic rx_line_neg_in, // receive negative rail
	input wire logic fmt_pos_in, // transmit formatter positive rail
	input wire logic fmt_neg_in, // transmit formatter negative rail
	output logic tx_line_pos_out, // transmit positive rail
	output logic tx_line_neg_out, // transmit negative rail
	output logic framer_pos_out, // positive rail toward receive framer
	output logic framer_neg_out, // negative rail toward receive framer
	output logic line_if_reset_out, // clock recovery/jitter attenuator reset pulse
	output logic rx_elastic_reset_out, // receive elastic store minimum-delay pulse
	output logic tx_elastic_reset_out, // transmit elastic store reset pulse
	output logic sync_input_select_out, // receiver expects sync clock when high
	output logic driver_open_drain_out, // line drivers in open-drain mode
	output logic remote_loopback_out // remote loopback active
);

	// whole block state lives in one register so reset and update stay in one place
	typedef struct packed {
		// register bus side
		logic [7:0] ctrl;
		logic [2:0][7:0] irq_mask;
		// status polling: latched bits, readable copy, last mask written
		logic [5:0][7:0] lat;
		logic [5:0][7:0] copy;
		logic [5:0][7:0] mask;
		// alarm change tracking for the interrupt
		logic [3:0] alarm_prev;
		logic [3:0] alarm_chg;
		// bus answer and interrupt
		logic [7:0] rdata;
		logic int_n;
		// one-cycle control pulses
		logic line_if_reset_p;
		logic rx_elastic_reset_p;
		logic tx_elastic_reset_p;
		// line rails and pattern generator
		logic tx_pos;
		logic tx_neg;
		logic fr_pos;
		logic fr_neg;
		logic pat_one;
		logic pat_neg;
	} lcs_state_t;

	lcs_state_t s_q;
	lcs_state_t s_d;

	// next-state logic of the whole block
	always_comb
	begin
		logic hit;
		logic [2:0] idx;
		logic [7:0] rd_clr;
		logic [7:0] pend;
		logic [7:0] clr;
		logic [7:0] set;
		logic rd_a;
		logic pend_one;
		logic pend_two;
		logic pend_hdlc;
		logic any_pend;
		hit = 1'b0;
		idx = 3'd0;
		rd_clr = 8'h00;
		pend = 8'h00;
		clr = 8'h00;
		set = 8'h00;
		rd_a = 1'b0;
		pend_one = 1'b0;
		pend_two = 1'b0;
		pend_hdlc = 1'b0;
		any_pend = 1'b0;
		// hold everything by default; the control pulses last a single cycle
		s_d = s_q;
		s_d.line_if_reset_p = 1'b0;
		s_d.rx_elastic_reset_p = 1'b0;
		s_d.tx_elastic_reset_p = 1'b0;

		// decode status register addresses
		case (addr_in)
			lcs_pkg::ADDR_STATUS_ONE:
			begin
				hit = 1'b1;
				idx = 3'(lcs_pkg::IDX_STATUS_ONE);
			end
			lcs_pkg::ADDR_STATUS_TWO:
			begin
				hit = 1'b1;
				idx = 3'(lcs_pkg::IDX_STATUS_TWO);
			end
			lcs_pkg::ADDR_RX_INFO_ONE:
			begin
				hit = 1'b1;
				idx = 3'(lcs_pkg::IDX_RX_INFO_ONE);
			end
			lcs_pkg::ADDR_RX_INFO_TWO:
			begin
				hit = 1'b1;
				idx = 3'(lcs_pkg::IDX_RX_INFO_TWO);
			end
			lcs_pkg::ADDR_RX_INFO_THREE:
			begin
				hit = 1'b1;
				idx = 3'(lcs_pkg::IDX_RX_INFO_THREE);
			end
			lcs_pkg::ADDR_HDLC_STATUS:
			begin
				hit = 1'b1;
				idx = 3'(lcs_pkg::IDX_HDLC_STATUS);
			end
			default:
			begin
				hit = 1'b0;
				idx = 3'd0;
			end
		endcase

		// control and mask register writes; the reserved bit is held low
		if (wr_in)
		begin
			case (addr_in)
				lcs_pkg::ADDR_LINE_IF_CTRL:
				begin
					s_d.ctrl = wdata_in;
					s_d.ctrl[lcs_pkg::BIT_RESERVED] = 1'b0;
					// pulses fire only on a zero-to-one change, so rewriting a one is harmless;
					// the host must wait for a stable receive system clock before the store reset
					s_d.line_if_reset_p = wdata_in[lcs_pkg::BIT_LINE_IF_RESET]
						& ~s_q.ctrl[lcs_pkg::BIT_LINE_IF_RESET];
					s_d.rx_elastic_reset_p = wdata_in[lcs_pkg::BIT_RX_ELASTIC_RESET]
						& ~s_q.ctrl[lcs_pkg::BIT_RX_ELASTIC_RESET];
					s_d.tx_elastic_reset_p = wdata_in[lcs_pkg::BIT_TX_ELASTIC_RESET]
						& ~s_q.ctrl[lcs_pkg::BIT_TX_ELASTIC_RESET];
				end
				lcs_pkg::ADDR_IRQ_MASK_ONE: s_d.irq_mask[0] = wdata_in;
				lcs_pkg::ADDR_IRQ_MASK_TWO: s_d.irq_mask[1] = wdata_in;
				lcs_pkg::ADDR_HDLC_IRQ_MASK: s_d.irq_mask[2] = wdata_in;
				default: s_d.irq_mask = s_q.irq_mask;
			endcase
		end

		// mask write refreshes only the selected positions of the copy;
		// the mask is kept so a later read clears only what the host asked for
		if (wr_in && hit)
		begin
			s_d.mask[idx] = wdata_in;
			s_d.copy[idx] = (wdata_in & s_q.lat[idx]) | (~wdata_in & s_q.copy[idx]);
		end

		// a read clears what it returned as one among the masked positions
		if (rd_in && hit)
			rd_clr = s_q.copy[idx] & s_q.mask[idx];

		// latch events; set wins over a clear in the same cycle
		for (int i = 0; i < lcs_pkg::NUM_STATUS; i++)
		begin
			clr = (3'(i) == idx) ? rd_clr : 8'h00;
			set = status_set_in[i*8 +: 8];
			// live alarm levels set their bit every cycle, so a read cannot clear them
			if (i == lcs_pkg::IDX_STATUS_ONE)
				set = set | {4'h0, alarm_in};
			s_d.lat[i] = (s_q.lat[i] & ~clr) | set;
		end

		// alarm changes in both directions raise a pending interrupt until that bit is read
		s_d.alarm_prev = alarm_in;
		for (int a = 0; a < lcs_pkg::NUM_ALARMS; a++)
		begin
			rd_a = (idx == 3'(lcs_pkg::IDX_STATUS_ONE)) && rd_clr[a];
			s_d.alarm_chg[a] = (s_q.alarm_chg[a] & ~rd_a) | (alarm_in[a] ^ s_q.alarm_prev[a]);
		end

		// interrupt sources: only the two status registers and hdlc status
		// alarm positions of status one use the change flag, not the level, so a
		// persisting alarm can be acknowledged and the pin released
		pend = (s_q.lat[lcs_pkg::IDX_STATUS_ONE] & ~lcs_pkg::STATUS_ONE_ALARM_MASK)
			| {4'h0, s_q.alarm_chg};
		// each source gated by its own mask bit
		pend_one = |(pend & s_q.irq_mask[0]);
		pend_two = |(s_q.lat[lcs_pkg::IDX_STATUS_TWO] & s_q.irq_mask[1]);
		pend_hdlc = |(s_q.lat[lcs_pkg::IDX_HDLC_STATUS] & s_q.irq_mask[2]);
		// information registers never reach the pin
		any_pend = pend_one | pend_two | pend_hdlc;
		s_d.int_n = ~any_pend;

		// read data, answered one cycle after the strobe;
		// reads of control and mask registers have no side effects
		if (rd_in)
		begin
			if (hit)
				s_d.rdata = s_q.copy[idx];
			else
			begin
				case (addr_in)
					lcs_pkg::ADDR_LINE_IF_CTRL: s_d.rdata = s_q.ctrl;
					lcs_pkg::ADDR_IRQ_MASK_ONE: s_d.rdata = s_q.irq_mask[0];
					lcs_pkg::ADDR_IRQ_MASK_TWO: s_d.rdata = s_q.irq_mask[1];
					lcs_pkg::ADDR_HDLC_IRQ_MASK: s_d.rdata = s_q.irq_mask[2];
					default: s_d.rdata = lcs_pkg::UNMAPPED_READ;
				endcase
			end
		end

		// framer always sees the receive line, loopback or not
		s_d.fr_pos = rx_line_pos_in;
		s_d.fr_neg = rx_line_neg_in;

		// alternating pattern: a mark every other bit, marks alternate polarity
		if (tx_bit_en_in)
		begin
			s_d.pat_one = ~s_q.pat_one;
			if (s_q.pat_one)
				s_d.pat_neg = ~s_q.pat_neg;
		end

		// transmit selection; loopback wins over the test pattern so a far-end loop test
		// is never masked by a forgotten pattern bit
		if (s_q.ctrl[lcs_pkg::BIT_REMOTE_LOOPBACK])
		begin
			s_d.tx_pos = rx_line_pos_in;
			s_d.tx_neg = rx_line_neg_in;
		end
		else if (s_q.ctrl[lcs_pkg::BIT_TEST_PATTERN])
		begin
			s_d.tx_pos = s_q.pat_one & ~s_q.pat_neg;
			s_d.tx_neg = s_q.pat_one & s_q.pat_neg;
		end
		else
		begin
			s_d.tx_pos = fmt_pos_in;
			s_d.tx_neg = fmt_neg_in;
		end
	end

	// single state register
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			s_q <= '0;
			s_q.ctrl <= lcs_pkg::LINE_IF_CTRL_RST;
			s_q.irq_mask <= {3{lcs_pkg::IRQ_MASK_RST}};
			s_q.lat <= {6{lcs_pkg::STATUS_RST}};
			s_q.copy <= {6{lcs_pkg::STATUS_RST}};
			s_q.int_n <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// outputs straight from the state register
	assign rdata_out = s_q.rdata;
	assign int_n_out = s_q.int_n;
	// line rails toward the transmitter and the framer
	assign tx_line_pos_out = s_q.tx_pos;
	assign tx_line_neg_out = s_q.tx_neg;
	assign framer_pos_out = s_q.fr_pos;
	assign framer_neg_out = s_q.fr_neg;
	// one-cycle pulses toward the recovery, attenuator and elastic store logic
	assign line_if_reset_out = s_q.line_if_reset_p;
	assign rx_elastic_reset_out = s_q.rx_elastic_reset_p;
	assign tx_elastic_reset_out = s_q.tx_elastic_reset_p;
	// control levels; sync select is receiver-only, the transmit path never looks at it
	assign sync_input_select_out = s_q.ctrl[lcs_pkg::BIT_SYNC_INPUT_SELECT];
	assign driver_open_drain_out = s_q.ctrl[lcs_pkg::BIT_DRIVER_OPEN_DRAIN];
	assign remote_loopback_out = s_q.ctrl[lcs_pkg::BIT_REMOTE_LOOPBACK];

endmodule : lcs_top

// file: tb/lcs_top_properties.sv
// checker: timing relations on the ports of the line control block
`timescale 1ns/10ps
module lcs_top_properties (
	input wire logic core_clk_in, // clock
	input wire logic arst_n_in, // reset
	input wire logic [7:0] addr_in, // address
	input wire logic [7:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	input wire logic [7:0] rdata_out, // read data
	input wire logic int_n_out, // interrupt
	input wire logic rx_line_pos_in, // rx rail
	input wire logic rx_line_neg_in, // rx rail
	input wire logic tx_line_pos_out, // tx rail
	input wire logic tx_line_neg_out, // tx rail
	input wire logic framer_pos_out, // framer rail
	input wire logic line_if_reset_out, // reset pulse
	input wire logic rx_elastic_reset_out, // store pulse
	input wire logic sync_input_select_out, // sync select
	input wire logic driver_open_drain_out, // open drain
	input wire logic remote_loopback_out // loopback
);
	default clocking dc @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// control write; a pulse must trace back to one with its bit set
	wire logic ctrl_wr = wr_in && (addr_in == lcs_pkg::ADDR_LINE_IF_CTRL);
	a_loop_bit_stored: assert property (ctrl_wr |=>
		remote_loopback_out == $past(wdata_in[lcs_pkg::BIT_REMOTE_LOOPBACK]))
		else $error("loopback bit not stored");
	a_sync_bit_stored: assert property (ctrl_wr |=>
		sync_input_select_out == $past(wdata_in[lcs_pkg::BIT_SYNC_INPUT_SELECT]))
		else $error("sync select not stored");
	a_drain_bit_stored: assert property (ctrl_wr |=>
		driver_open_drain_out == $past(wdata_in[lcs_pkg::BIT_DRIVER_OPEN_DRAIN]))
		else $error("open drain not stored");
	a_line_reset_cause: assert property (line_if_reset_out |->
		$past(ctrl_wr && wdata_in[lcs_pkg::BIT_LINE_IF_RESET]))
		else $error("line reset pulse without write");
	a_store_reset_cause: assert property (rx_elastic_reset_out |->
		$past(ctrl_wr && wdata_in[lcs_pkg::BIT_RX_ELASTIC_RESET]))
		else $error("store reset pulse without write");
	a_loop_data_path: assert property ($past(remote_loopback_out) |->
		{tx_line_pos_out, tx_line_neg_out} == $past({rx_line_pos_in, rx_line_neg_in}))
		else $error("loopback data wrong");
	a_framer_feed: assert property ($past(arst_n_in) |->
		framer_pos_out == $past(rx_line_pos_in))
		else $error("framer feed wrong");
	a_rdata_holds: assert property (!$past(rd_in) |-> $stable(rdata_out))
		else $error("read data moved");
	c_loop_on: cover property (ctrl_wr && wdata_in[6]);
	c_irq_low: cover property (!int_n_out);
	c_line_reset: cover property (line_if_reset_out);
endmodule : lcs_top_properties
bind lcs_top lcs_top_properties i_props (.core_clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in,
	.rd_in, .rdata_out, .int_n_out, .rx_line_pos_in, .rx_line_neg_in, .tx_line_pos_out,
	.tx_line_neg_out, .framer_pos_out, .line_if_reset_out, .rx_elastic_reset_out,
	.sync_input_select_out, .driver_open_drain_out, .remote_loopback_out);

// file: tb/lcs_host_model.sv
// host model: processor side of the parallel control port
`timescale 1ns/10ps
module lcs_host_model (
	input wire logic clk_in, // core clock
	input wire logic [7:0] rdata_in, // read data
	output logic [7:0] addr_out, // address
	output logic [7:0] wdata_out, // write data
	output logic wr_out, // write strobe
	output logic rd_out // read strobe
);
	// strobes idle from time zero
	initial
	begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// strobe for one taking edge, fields held across it
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in) #1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in) #1;
		wr_out = 1'b0;
	endtask : wr_reg
	// data stands until the next read, so take it one edge late
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in) #1;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in) #1;
		rd_out = 1'b0;
		@(posedge clk_in) #1;
		d = rdata_in;
	endtask : rd_reg
	// mask, read, write back read and mask so late events survive
	task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
		wr_reg(a, m);
		rd_reg(a, d);
		wr_reg(a, d & m);
	endtask : poll
endmodule : lcs_host_model

// file: tb/lcs_top_tb.sv
// testbench: control register, line paths, status polling and interrupt
`timescale 1ns/10ps
module lcs_top_tb;
	logic core_clk_in, arst_n_in, wr_in, rd_in, int_n_out, tx_bit_en_in;
	logic [7:0] addr_in, wdata_in, rdata_out, d;
	logic [47:0] status_set_in;
	logic [3:0] alarm_in;
	logic rx_line_pos_in, rx_line_neg_in, fmt_pos_in, fmt_neg_in, tx_line_pos_out, tx_line_neg_out;
	logic framer_pos_out, framer_neg_out, line_if_reset_out, rx_elastic_reset_out;
	logic tx_elastic_reset_out, sync_input_select_out, driver_open_drain_out, remote_loopback_out;
	int fails = 0;
	int compares = 0;
	lcs_top i_dut (.core_clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.int_n_out, .status_set_in, .alarm_in, .tx_bit_en_in, .rx_line_pos_in, .rx_line_neg_in,
		.fmt_pos_in, .fmt_neg_in, .tx_line_pos_out, .tx_line_neg_out, .framer_pos_out,
		.framer_neg_out, .line_if_reset_out, .rx_elastic_reset_out, .tx_elastic_reset_out,
		.sync_input_select_out, .driver_open_drain_out, .remote_loopback_out);
	lcs_host_model i_host (.clk_in(core_clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
		.wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
	// 20 MHz
	always #25 core_clk_in = ~core_clk_in;
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : tick
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// all writable bits, reserved bit forced low, loopback beats formatter
	task automatic t_ctrl;
		i_host.wr_reg(lcs_pkg::ADDR_LINE_IF_CTRL, 8'hFF);
		chk("pulses", 8'h07, {5'h00, line_if_reset_out, rx_elastic_reset_out,
			tx_elastic_reset_out});
		i_host.wr_reg(lcs_pkg::ADDR_LINE_IF_CTRL, 8'hFF);
		chk("no repulse", 8'h00, {5'h00, line_if_reset_out, rx_elastic_reset_out,
			tx_elastic_reset_out});
		i_host.rd_reg(lcs_pkg::ADDR_LINE_IF_CTRL, d);
		chk("ctrl", 8'hF7, d);
		chk("levels", 8'h07, {5'h00, remote_loopback_out, sync_input_select_out,
			driver_open_drain_out});
		i_host.rd_reg(8'hFF, d);
		chk("unmapped", lcs_pkg::UNMAPPED_READ, d);
		rx_line_pos_in = 1'b1;
		fmt_neg_in = 1'b1;
		tick(2);
		chk("loop", 8'h02, {6'h00, tx_line_pos_out, tx_line_neg_out});
		chk("framer", 8'h02, {6'h00, framer_pos_out, framer_neg_out});
		i_host.wr_reg(lcs_pkg::ADDR_LINE_IF_CTRL, 8'h00);
		tick(2);
		chk("formatter", 8'h01, {6'h00, tx_line_pos_out, tx_line_neg_out});
		$display("t_ctrl done");
	endtask : t_ctrl
	// four bit periods of 1010: two marks, one on each rail
	task automatic t_pattern;
		logic [7:0] ones;
		logic [7:0] pos;
		ones = 8'h00;
		pos = 8'h00;
		i_host.wr_reg(lcs_pkg::ADDR_LINE_IF_CTRL, 8'h02);
		repeat (4)
		begin
			tx_bit_en_in = 1'b1;
			tick(1);
			tx_bit_en_in = 1'b0;
			tick(2);
			ones = ones + tx_line_pos_out + tx_line_neg_out;
			pos = pos + tx_line_pos_out;
		end
		chk("marks", 8'h02, ones);
		chk("pos marks", 8'h01, pos);
		i_host.wr_reg(lcs_pkg::ADDR_LINE_IF_CTRL, 8'h00);
		$display("t_pattern done");
	endtask : t_pattern
	// two events, one unmasked; a zero mask position keeps its held copy
	task automatic t_event;
		i_host.wr_reg(lcs_pkg::ADDR_IRQ_MASK_TWO, 8'h01);
		i_host.wr_reg(lcs_pkg::ADDR_HDLC_IRQ_MASK, 8'h01);
		status_set_in = 48'h0000_0000_0300; // status two bits 0 and 1
		status_set_in[23] = 1'b1; // info one bit 7
		tick(1);
		status_set_in = 48'h0;
		tick(3);
		chk("int event", 8'h00, {7'h00, int_n_out});
		i_host.poll(lcs_pkg::ADDR_STATUS_TWO, 8'h01, d);
		chk("status two first", 8'h01, d);
		tick(3);
		chk("int freed", 8'h01, {7'h00, int_n_out});
		// bit 0 fires again but is masked out of the next refresh
		status_set_in[8] = 1'b1;
		tick(1);
		status_set_in = 48'h0;
		i_host.poll(lcs_pkg::ADDR_STATUS_TWO, 8'h02, d);
		chk("status two held", 8'h02, d);
		i_host.poll(lcs_pkg::ADDR_STATUS_TWO, 8'h03, d);
		chk("status two again", 8'h01, d);
		i_host.poll(lcs_pkg::ADDR_STATUS_TWO, 8'h03, d);
		chk("status two clear", 8'h00, d);
		i_host.poll(lcs_pkg::ADDR_RX_INFO_ONE, 8'hFF, d);
		chk("rx info one", 8'h80, d);
		status_set_in[40] = 1'b1;
		tick(1);
		status_set_in = 48'h0;
		tick(3);
		chk("int hdlc", 8'h00, {7'h00, int_n_out});
		i_host.poll(lcs_pkg::ADDR_HDLC_STATUS, 8'h01, d);
		tick(3);
		chk("int hdlc off", 8'h01, {7'h00, int_n_out});
		$display("t_event done");
	endtask : t_event
	// alarm raises on both edges and frees on read while still present
	task automatic t_alarm;
		i_host.wr_reg(lcs_pkg::ADDR_IRQ_MASK_ONE, 8'h01);
		alarm_in[0] = 1'b1;
		tick(4);
		chk("int rise", 8'h00, {7'h00, int_n_out});
		i_host.poll(lcs_pkg::ADDR_STATUS_ONE, 8'h01, d);
		tick(3);
		chk("int freed", 8'h01, {7'h00, int_n_out});
		i_host.poll(lcs_pkg::ADDR_STATUS_ONE, 8'h01, d);
		chk("status one kept", 8'h01, d);
		alarm_in[0] = 1'b0;
		tick(4);
		chk("int fall", 8'h00, {7'h00, int_n_out});
		i_host.poll(lcs_pkg::ADDR_STATUS_ONE, 8'h01, d);
		tick(3);
		chk("int gone", 8'h01, {7'h00, int_n_out});
		$display("t_alarm done");
	endtask : t_alarm
	task automatic end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	// the run needs about 140 cycles; this is far beyond it
	initial
	begin
		#200000;
		fails++;
		end_sim();
	end
	initial
	begin
		core_clk_in = 1'b0;
		arst_n_in = 1'b0;
		status_set_in = 48'h0;
		alarm_in = 4'h0;
		tx_bit_en_in = 1'b0;
		{rx_line_pos_in, rx_line_neg_in, fmt_pos_in, fmt_neg_in} = 4'h0;
		tick(12);
		arst_n_in = 1'b1;
		t_ctrl();
		t_pattern();
		t_event();
		t_alarm();
		end_sim();
	end
endmodule : lcs_top_tb
